// >>> baud_counter.sv
module baud_counter #(
	parameter int unsigned WIDTH = start_gen_pkg::BAUD_W
) (
	input wire logic clk,
	input wire logic rst_b,
	baud_if.counter bus
);
	logic [WIDTH-1:0] count_q;
	logic running_q;
	logic expired_q;

	// ************************************************************
	// Reloadable down counter; one pulse on reaching zero
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= WIDTH'(start_gen_pkg::BAUD_RESET);
			running_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (bus.halt) begin
			running_q <= 1'b0;
			expired_q <= 1'b0;
		end else if (bus.load) begin
			count_q <= bus.reload;
			running_q <= 1'b1;
			expired_q <= 1'b0;
		end else if (running_q) begin
			if (count_q == WIDTH'(start_gen_pkg::BAUD_ZERO)) begin
				running_q <= 1'b0;
				expired_q <= 1'b1;
			end else begin
				count_q <= count_q - WIDTH'(start_gen_pkg::BAUD_ONE);
				expired_q <= 1'b0;
			end
		end else begin
			expired_q <= 1'b0;
		end
	end

	assign bus.expired = expired_q;
endmodule : baud_counter

// >>> baud_if.sv
interface baud_if #(
	parameter int unsigned WIDTH = start_gen_pkg::BAUD_W
);
	logic load;
	logic halt;
	logic [WIDTH-1:0] reload;
	logic expired;

	modport ctrl (
		output load,
		output halt,
		output reload,
		input expired
	);
	modport counter (
		input load,
		input halt,
		input reload,
		output expired
	);
endinterface : baud_if

// >>> i2c_bus_model.sv
module i2c_bus_model (
	input wire logic data_oe,
	input wire logic clock_oe,
	input wire logic hold_data,
	input wire logic hold_clock,
	output logic data_line,
	output logic clock_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-ups: a released line floats high
	assign data_line = !(data_oe || hold_data);
	assign clock_line = !(clock_oe || hold_clock);
endmodule : i2c_bus_model

// >>> i2c_master_start_generator.sv
// Behaviour
// - Setting the start request bit begins a start condition.
// - Both lines high at request: load baud counter from reload value, count.
// - Counter expiry with both lines high: drive data low, release clock.
// - Data falling while clock high sets the start-detected flag.
// - After driving data low, reload counter for one more period.
// - Second expiry clears request, halts counter, keeps data low.
// - Either line low at request: collision flag, abort, idle.
// - Clock low before data driven low: collision flag, abort, idle.
module i2c_master_start_generator #(
	parameter int unsigned BAUD_W = start_gen_pkg::BAUD_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start_request_set,
	input wire logic [BAUD_W-1:0] baud_reload_value,
	input wire logic start_flag_clear,
	input wire logic collision_flag_clear,
	input wire logic release_data,
	input wire logic data_line_in,
	input wire logic clock_line_in,
	output logic data_line_out,
	output logic data_line_oe,
	output logic clock_line_out,
	output logic clock_line_oe,
	output logic start_request_bit,
	output logic start_detected,
	output logic bus_collision_flag,
	output logic busy
);
	start_gen_pkg::start_state_t state_q;
	start_gen_pkg::start_state_t state_d;
	logic request_bit_d;
	logic data_low_q;
	logic data_low_d;
	logic data_prev_q;
	logic start_detected_d;
	logic collision_flag_d;
	logic lines_high;
	logic idle_request;
	logic hold_release;
	logic data_fall;
	logic collide_at_request;
	logic collide_in_hold;
	logic collide;
	logic begin_ok;
	logic drive_low;
	logic finish;

	baud_if #(.WIDTH(BAUD_W)) baud ();

	baud_counter #(
		.WIDTH(BAUD_W)
	) u_baud (
		.clk(clk),
		.rst_b(rst_b),
		.bus(baud)
	);

	// ************************************************************
	// Line conditions
	// ************************************************************
	// Request is seen only from idle; re-setting mid-sequence only matters in the finish or collision cycle, where set beats clear
	assign idle_request = (state_q == start_gen_pkg::ST_IDLE) && start_request_bit;
	assign lines_high = data_line_in && clock_line_in;
	assign hold_release = release_data && (state_q == start_gen_pkg::ST_IDLE);
	assign data_fall = data_prev_q && !data_line_in && clock_line_in;

	// ************************************************************
	// Sequence decisions
	// ************************************************************
	assign begin_ok = idle_request && lines_high;
	// Anything short of both lines high counts, so a half-held bus is never started on
	assign collide_at_request = idle_request && !lines_high;
	// Clock pulled low by another master before our data edge
	assign collide_in_hold = (state_q == start_gen_pkg::ST_HOLD_HIGH)
		&& !clock_line_in;
	assign collide = collide_at_request || collide_in_hold;
	// Expiry with data held low elsewhere drives nothing; a clock collision ends the wait
	assign drive_low = (state_q == start_gen_pkg::ST_HOLD_HIGH) && baud.expired
		&& lines_high;
	assign finish = (state_q == start_gen_pkg::ST_HOLD_LOW) && baud.expired;

	assign baud.load = begin_ok || drive_low;
	assign baud.halt = collide || finish;
	assign baud.reload = baud_reload_value;

	// ************************************************************
	// State
	// ************************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			start_gen_pkg::ST_IDLE: begin
				if (begin_ok) begin
					state_d = start_gen_pkg::ST_HOLD_HIGH;
				end
			end
			start_gen_pkg::ST_HOLD_HIGH: begin
				if (collide) begin
					state_d = start_gen_pkg::ST_IDLE;
				end else if (drive_low) begin
					state_d = start_gen_pkg::ST_HOLD_LOW;
				end
			end
			start_gen_pkg::ST_HOLD_LOW: begin
				if (finish) begin
					state_d = start_gen_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= start_gen_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ************************************************************
	// Request bit: software sets, hardware clears
	// ************************************************************
	always_comb begin
		request_bit_d = start_request_bit;
		if (start_request_set) begin
			request_bit_d = 1'b1;
		end else if (finish || collide) begin
			request_bit_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_request_bit <= 1'b0;
		end else begin
			start_request_bit <= request_bit_d;
		end
	end

	// ************************************************************
	// Data line hold; kept low after the sequence until released
	// ************************************************************
	always_comb begin
		data_low_d = data_low_q;
		if (drive_low) begin
			data_low_d = 1'b1;
		end else if (hold_release) begin
			data_low_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_low_q <= 1'b0;
		end else begin
			data_low_q <= data_low_d;
		end
	end

	// ************************************************************
	// Pin drivers; open drain, so the level driven is always low
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_line_out <= 1'b0;
			data_line_oe <= 1'b0;
		end else begin
			data_line_out <= 1'b0;
			data_line_oe <= data_low_d;
		end
	end

	// Clock is never pulled here; clock stretching belongs to the rest of the engine
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clock_line_out <= 1'b0;
			clock_line_oe <= 1'b0;
		end else begin
			clock_line_out <= 1'b0;
			clock_line_oe <= 1'b0;
		end
	end

	// High from the load edge; drops one edge after the request bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else begin
			busy <= (state_q != start_gen_pkg::ST_IDLE) || begin_ok;
		end
	end

	// ************************************************************
	// Status flags; a set wins over a clear in the same cycle
	// ************************************************************
	// Reset level matches the pulled-up idle line, so no false edge after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_prev_q <= 1'b1;
		end else begin
			data_prev_q <= data_line_in;
		end
	end

	always_comb begin
		start_detected_d = start_detected;
		if (data_fall) begin
			start_detected_d = 1'b1;
		end else if (start_flag_clear) begin
			start_detected_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_detected <= 1'b0;
		end else begin
			start_detected <= start_detected_d;
		end
	end

	always_comb begin
		collision_flag_d = bus_collision_flag;
		if (collide) begin
			collision_flag_d = 1'b1;
		end else if (collision_flag_clear) begin
			collision_flag_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_collision_flag <= 1'b0;
		end else begin
			bus_collision_flag <= collision_flag_d;
		end
	end
endmodule : i2c_master_start_generator

// >>> start_gen_assertions.sv
module start_gen_assertions (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start_request_set,
	input wire logic data_line_in,
	input wire logic clock_line_in,
	input wire logic data_line_oe,
	input wire logic clock_line_oe,
	input wire logic start_request_bit,
	input wire logic start_detected,
	input wire logic bus_collision_flag,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	req_sets_bit_a: assert property (start_request_set |=> start_request_bit)
		else $error("request bit not set");
	lines_high_load_a: assert property (
		$rose(start_request_bit) && data_line_in && clock_line_in |=> busy)
		else $error("counter not started");
	drive_needs_high_a: assert property (
		$rose(data_line_oe) |-> $past(data_line_in) && $past(clock_line_in))
		else $error("drove data early");
	clock_released_a: assert property (!clock_line_oe) else $error("clock driven");
	start_seen_a: assert property (
		$fell(data_line_in) && clock_line_in |=> start_detected)
		else $error("start not flagged");
	second_period_a: assert property ($rose(data_line_oe) |-> start_request_bit [*2])
		else $error("second period skipped");
	end_holds_low_a: assert property (
		$fell(start_request_bit) && !bus_collision_flag |-> data_line_oe ##1 !busy)
		else $error("bad finish");
	low_at_req_a: assert property (
		$rose(start_request_bit) && !data_line_in && !clock_line_in
		|-> ##[1:2] bus_collision_flag)
		else $error("collision missed");
	clock_low_abort_a: assert property (
		busy && !data_line_oe && !clock_line_in
		|-> ##[1:2] (bus_collision_flag && !start_request_bit))
		else $error("no abort");
	cover property (start_detected);
	cover property (bus_collision_flag && !data_line_oe);
	cover property ($fell(start_request_bit) && data_line_oe);
endmodule : start_gen_assertions
bind i2c_master_start_generator start_gen_assertions chk (.*);

// >>> start_gen_pkg.sv
package start_gen_pkg;
	// ************************************************************
	// Baud counter geometry
	// ************************************************************
	localparam int unsigned BAUD_W = 8;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [7:0] BAUD_ONE = 8'h01;
	localparam logic [7:0] BAUD_ZERO = 8'h00;

	// ************************************************************
	// Sequence states
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HOLD_HIGH,
		ST_HOLD_LOW
	} start_state_t;
endpackage : start_gen_pkg

// >>> tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, req = 0, fclr = 0, cclr = 0, rel = 0, hd = 0, hc = 0;
	logic [7:0] rv = 8'h03;
	logic dli, cli, doe, coe, sbit, sdet, bcol, busy, dlo, clo;
	int bad_count = 0, compares = 0, n;
	always #25 clk = ~clk;
	i2c_master_start_generator dut (.clk(clk), .rst_b(rst_b), .start_request_set(req),
		.baud_reload_value(rv), .start_flag_clear(fclr), .collision_flag_clear(cclr),
		.release_data(rel), .data_line_in(dli), .clock_line_in(cli), .data_line_out(dlo),
		.data_line_oe(doe), .clock_line_out(clo), .clock_line_oe(coe), .start_request_bit(sbit),
		.start_detected(sdet), .bus_collision_flag(bcol), .busy(busy));
	i2c_bus_model bus (.data_oe(doe), .clock_oe(coe), .hold_data(hd), .hold_clock(hc),
		.data_line(dli), .clock_line(cli));
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#5;
	endtask : cyc
	task chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// Bounded wait so a stuck sequence cannot hang the run
	task start;
		req = 1;
		cyc(1);
		req = 0;
		n = 0;
		while (sbit === 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
		// Running out of the wait is a failure in itself
		if (n >= 600) bad_count++;
	endtask : start
	task final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	initial begin
		#200000;
		bad_count++;
		final_report;
	end
	initial begin
		cyc(2);
		rst_b = 1;
		start;
		chk(doe, 1);
		chk(sdet, 1);
		// Load edge, reload+1 counts, drive edge, reload+1 counts, finish edge
		chk(8'(n), 8'h0B);
		chk({coe, sbit, bcol}, 3'h0);
		chk({dlo, clo}, 2'h0);
		cyc(1);
		chk({busy, doe}, 2'h1);
		$display("test normal start done");
		rel = 1;
		fclr = 1;
		cyc(1);
		{rel, fclr, hd, hc} = 4'h3;
		cyc(1);
		chk({doe, sdet}, 0);
		start;
		cyc(2);
		chk({bcol, doe, sbit}, 3'h4);
		$display("test low lines done");
		{hd, hc, cclr, rv} = {3'h1, 8'h08};
		cyc(1);
		cclr = 0;
		req = 1;
		cyc(1);
		req = 0;
		cyc(4);
		hc = 1;
		cyc(3);
		chk({bcol, doe, sbit, sdet}, 4'h8);
		$display("test clock low done");
		final_report;
	end
endmodule : tb_top
